// *** hdl/ncao_host.sv ***
// Host controller issuing column-address operations to a NAND die.
// Assumes the die's pins are reached directly; inputs from pins are synchronised here.
//
// Behaviour
// - Random read is 05h, two column cycles, E0h, then output.
// - Wait we_high_to_read_delay after E0h before first read strobe.
// - With several dies, send 78h before 05h-E0h.
// - Two-plane read is 06h, two column, three row cycles, E0h.
// - Two-plane read picks a plane; reissue to switch planes.
// - While dies busy, send 78h to the wanted die before 06h-E0h.
// - 85h with two column cycles, then wait address_to_data_load_delay.
// - 85h only inside a program sequence before its confirm.
// - Five-cycle 85h waits address_to_data_load_delay before data.
// - Five-cycle 85h keeps die and plane bits as first given.
// - During internal move, 85h data overwrites cache bytes.
// - 05h-E0h changes only the column, keeping die and plane.
`timescale 1ns/1ps
`include "ncao_regs.svh"
module ncao_host #(
  parameter int DATA_DEPTH = 4
) (
  input  wire logic                  clock,
  input  wire logic                  rstn,
  input  wire logic                  opValid,
  output logic                       opReady,
  input  wire ncao_pkg::ncao_op_t    opKind,
  input  wire logic [15:0]           opColumn,
  input  wire logic [23:0]           opRow,
  input  wire logic [15:0]           opLength,
  input  wire logic                  opMultiDie,
  input  wire logic                  opInProgram,
  input  wire logic [7:0]            wrData,
  input  wire logic                  wrValid,
  output logic                       wrReady,
  output logic [7:0]                 rdData,
  output logic                       rdValid,
  input  wire logic                  rdReady,
  output logic                       opDone,
  output logic                       opRefused,
  output logic                       nandCle,
  output logic                       nandAle,
  output logic                       nandWe_n,
  output logic                       nandRe_n,
  output logic [7:0]                 nandIoOut,
  output logic                       nandIoOe,
  input  wire logic [7:0]            nandIoIn
);
  typedef struct packed {
    ncao_pkg::ncao_state_t st;
    ncao_pkg::ncao_op_t    op;
    logic [15:0] col;
    logic [23:0] row;
    logic [15:0] left;
    logic [2:0]  idx;
    logic [7:0]  tmr;
    logic        half;
    logic        mdie;
    logic        opReady;
    logic        opDone;
    logic        opRefused;
    logic        cle;
    logic        ale;
    logic        we_n;
    logic        re_n;
    logic [7:0]  io;
    logic        oe;
    logic [7:0]  rd;
    logic        rdPush;
    logic        wrPop;
  } ncao_host_state_t;

  ncao_host_state_t cur;
  ncao_host_state_t next_cur;
  logic [7:0] ioSync1;
  logic [7:0] ioSync2;
  logic [7:0] wfData;
  logic       wfValid;
  logic       rfReady;

  // Two-stage synchroniser on the data pins
  always_ff @(posedge clock) begin
    ioSync1 <= nandIoIn;
    ioSync2 <= ioSync1;
  end

  // Write data buffered before driving pins; a full FIFO stalls host source
  ncao_fifo #(.WIDTH(8), .DEPTH(DATA_DEPTH)) wrFifo (
    .clock    (clock),
    .rstn     (rstn),
    .inData   (wrData),
    .inValid  (wrValid),
    .inReady  (wrReady),
    .outData  (wfData),
    .outValid (wfValid),
    .outReady (cur.wrPop)
  );

  // Read data buffered; a full FIFO holds off further read strobes
  ncao_fifo #(.WIDTH(8), .DEPTH(DATA_DEPTH)) rdFifo (
    .clock    (clock),
    .rstn     (rstn),
    .inData   (cur.rd),
    .inValid  (cur.rdPush),
    .inReady  (rfReady),
    .outData  (rdData),
    .outValid (rdValid),
    .outReady (rdReady)
  );

  // Control outputs straight from state
  assign opReady   = cur.opReady;
  assign opDone    = cur.opDone;
  assign opRefused = cur.opRefused;
  assign nandCle   = cur.cle;
  assign nandAle   = cur.ale;
  assign nandWe_n  = cur.we_n;
  assign nandRe_n  = cur.re_n;
  assign nandIoOut = cur.io;
  assign nandIoOe  = cur.oe;

  // Next-state logic: each bus cycle is a low then high write or read strobe phase
  always_comb begin
    next_cur        = cur;
    next_cur.opDone    = 1'b0;
    next_cur.opRefused = 1'b0;
    next_cur.rdPush    = 1'b0;
    next_cur.wrPop     = 1'b0;
    if (cur.tmr != 8'h00) begin
      next_cur.tmr = cur.tmr - 8'h01;
      // Latch enables stay one clock past the rising strobe, then drop
      if (!cur.half) begin
        next_cur.cle = 1'b0;
        next_cur.ale = 1'b0;
      end
    end else begin
      unique case (cur.st)
        ncao_pkg::NCAO_IDLE: begin
          next_cur.opReady = 1'b1;
          next_cur.oe      = 1'b0;
          if (opValid && cur.opReady) begin
            next_cur.opReady = 1'b0;
            next_cur.op   = opKind;
            next_cur.col  = opColumn;
            next_cur.row  = opRow;
            next_cur.left = opLength;
            next_cur.mdie = opMultiDie;
            next_cur.idx  = 3'd0;
            next_cur.half = 1'b0;
            if ((opKind == ncao_pkg::NCAO_OP_INPUT_COL ||
                 opKind == ncao_pkg::NCAO_OP_INPUT_ROW) && !opInProgram) begin
              next_cur.opRefused = 1'b1;
              next_cur.opReady   = 1'b1;
            end else if (opMultiDie || opKind == ncao_pkg::NCAO_OP_READ_PLANE) begin
              next_cur.st = ncao_pkg::NCAO_STAT_CMD;
            end else begin
              next_cur.st = ncao_pkg::NCAO_CMD;
            end
          end
        end
        // Command, address and confirm write cycles, including enhanced status 78h to one die
        ncao_pkg::NCAO_STAT_CMD,
        ncao_pkg::NCAO_CMD,
        ncao_pkg::NCAO_COL,
        ncao_pkg::NCAO_ROW,
        ncao_pkg::NCAO_STAT_ROW,
        ncao_pkg::NCAO_CONFIRM: begin
          next_cur.oe  = 1'b1;
          next_cur.cle = (cur.st == ncao_pkg::NCAO_STAT_CMD || cur.st == ncao_pkg::NCAO_CMD ||
                          cur.st == ncao_pkg::NCAO_CONFIRM);
          next_cur.ale = !next_cur.cle;
          unique case (cur.st)
            ncao_pkg::NCAO_STAT_CMD: next_cur.io = `NCAO_CMD_STATUS_ENH;
            ncao_pkg::NCAO_CMD: begin
              unique case (cur.op)
                ncao_pkg::NCAO_OP_READ_COL:   next_cur.io = `NCAO_CMD_RAND_READ;
                ncao_pkg::NCAO_OP_READ_PLANE: next_cur.io = `NCAO_CMD_RAND_READ_2PL;
                default:                      next_cur.io = `NCAO_CMD_RAND_INPUT;
              endcase
            end
            ncao_pkg::NCAO_COL: next_cur.io = cur.idx[0] ? cur.col[15:8] : cur.col[7:0];
            ncao_pkg::NCAO_CONFIRM: next_cur.io = `NCAO_CMD_READ_CONFIRM;
            default: next_cur.io = cur.idx[1] ? cur.row[23:16] :
                                   (cur.idx[0] ? cur.row[15:8] : cur.row[7:0]);
          endcase
          next_cur.tmr = 8'(`NCAO_CYC_WE);
          if (!cur.half) begin
            next_cur.we_n = 1'b0;
            next_cur.half = 1'b1;
          end else begin
            next_cur.we_n = 1'b1;
            next_cur.half = 1'b0;
            next_cur.idx  = cur.idx + 3'd1;
            unique case (cur.st)
              ncao_pkg::NCAO_STAT_CMD: begin
                next_cur.st = ncao_pkg::NCAO_STAT_ROW;
                next_cur.idx = 3'd0;
              end
              ncao_pkg::NCAO_STAT_ROW: if (cur.idx == 3'd2) begin
                next_cur.st  = ncao_pkg::NCAO_STAT_READ;
                next_cur.tmr = 8'(`NCAO_CYC_WHR);
                next_cur.oe  = 1'b0;
              end
              ncao_pkg::NCAO_CMD: begin
                next_cur.st = ncao_pkg::NCAO_COL;
                next_cur.idx = 3'd0;
              end
              ncao_pkg::NCAO_COL: if (cur.idx == 3'd1) begin
                next_cur.idx = 3'd0;
                unique case (cur.op)
                  ncao_pkg::NCAO_OP_READ_COL: next_cur.st = ncao_pkg::NCAO_CONFIRM;
                  ncao_pkg::NCAO_OP_INPUT_COL: begin
                    next_cur.st  = ncao_pkg::NCAO_WAIT;
                    next_cur.tmr = 8'(`NCAO_CYC_ADL);
                  end
                  default: next_cur.st = ncao_pkg::NCAO_ROW;
                endcase
              end
              ncao_pkg::NCAO_ROW: if (cur.idx == 3'd2) begin
                if (cur.op == ncao_pkg::NCAO_OP_INPUT_ROW) begin
                  next_cur.st  = ncao_pkg::NCAO_WAIT;
                  next_cur.tmr = 8'(`NCAO_CYC_ADL);
                end else begin
                  next_cur.st = ncao_pkg::NCAO_CONFIRM;
                end
              end
              default: begin
                next_cur.st  = ncao_pkg::NCAO_WAIT;
                next_cur.tmr = 8'(`NCAO_CYC_WHR);
              end
            endcase
          end
        end
        // Read status byte; refuse when die not in an accepting state
        ncao_pkg::NCAO_STAT_READ: begin
          if (!cur.half) begin
            next_cur.re_n = 1'b0;
            next_cur.half = 1'b1;
            next_cur.tmr  = 8'(`NCAO_CYC_REA);
          end else begin
            next_cur.re_n = 1'b1;
            next_cur.half = 1'b0;
            if (!ioSync2[`NCAO_SR_CACHE_RDY_BIT] ||
                (cur.op == ncao_pkg::NCAO_OP_READ_PLANE &&
                 !ioSync2[`NCAO_SR_ARRAY_RDY_BIT])) begin
              next_cur.st        = ncao_pkg::NCAO_IDLE;
              next_cur.opRefused = 1'b1;
            end else begin
              next_cur.st  = ncao_pkg::NCAO_CMD;
              next_cur.tmr = 8'(`NCAO_CYC_WE);
            end
          end
        end
        ncao_pkg::NCAO_WAIT: begin
          next_cur.st = ncao_pkg::NCAO_STREAM;
          next_cur.oe = (cur.op == ncao_pkg::NCAO_OP_INPUT_COL ||
                         cur.op == ncao_pkg::NCAO_OP_INPUT_ROW);
        end
        // Data phase: zero length is legal and ends at once
        ncao_pkg::NCAO_STREAM: begin
          if (cur.left == 16'h0000 && !cur.half) begin
            next_cur.st     = ncao_pkg::NCAO_IDLE;
            next_cur.opDone = 1'b1;
            next_cur.oe     = 1'b0;
          end else if (cur.oe) begin
            if (!cur.half && wfValid) begin
              next_cur.io    = wfData;
              next_cur.wrPop = 1'b1;
              next_cur.we_n  = 1'b0;
              next_cur.half  = 1'b1;
              next_cur.tmr   = 8'(`NCAO_CYC_WE);
            end else if (cur.half) begin
              next_cur.we_n = 1'b1;
              next_cur.half = 1'b0;
              next_cur.left = cur.left - 16'h0001;
              next_cur.col  = cur.col + 16'h0001;
              next_cur.tmr  = 8'(`NCAO_CYC_WE);
            end
          end else begin
            if (!cur.half && rfReady) begin
              next_cur.re_n = 1'b0;
              next_cur.half = 1'b1;
              next_cur.tmr  = 8'(`NCAO_CYC_REA);
            end else if (cur.half) begin
              next_cur.re_n   = 1'b1;
              next_cur.half   = 1'b0;
              next_cur.rd     = ioSync2;
              next_cur.rdPush = 1'b1;
              next_cur.left   = cur.left - 16'h0001;
              next_cur.col    = cur.col + 16'h0001;
              next_cur.tmr    = 8'(`NCAO_CYC_WE);
            end
          end
        end
      endcase
    end
  end

  // State register; multi-die use reuses the same sequences
  always_ff @(posedge clock) begin
    if (!rstn) begin
      cur      <= '0;
      cur.st   <= ncao_pkg::NCAO_IDLE;
      cur.we_n <= 1'b1;
      cur.re_n <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end
endmodule

// *** hdl/ncao_regs.svh ***
// Constants for the NAND column-address host controller.
// Assumes a 40 MHz clock; times are in ns, counts derived from them.
`ifndef NCAO_REGS_SVH
`define NCAO_REGS_SVH
`define NCAO_CMD_RAND_READ      8'h05
`define NCAO_CMD_RAND_READ_2PL  8'h06
`define NCAO_CMD_READ_CONFIRM   8'hE0
`define NCAO_CMD_RAND_INPUT     8'h85
`define NCAO_CMD_STATUS_ENH     8'h78
`define NCAO_CMD_STATUS         8'h70
`define NCAO_SR_CACHE_RDY_BIT   6
`define NCAO_SR_ARRAY_RDY_BIT   5
`define NCAO_CLK_PERIOD_NS      25
`define NCAO_T_CYCLE_NS         30
`define NCAO_T_WHR_NS           80
`define NCAO_T_ADL_NS           100
`define NCAO_T_REA_NS           20
`define NCAO_CYC_WE   ((`NCAO_T_CYCLE_NS + `NCAO_CLK_PERIOD_NS - 1) / `NCAO_CLK_PERIOD_NS)
`define NCAO_CYC_WHR  ((`NCAO_T_WHR_NS + `NCAO_CLK_PERIOD_NS - 1) / `NCAO_CLK_PERIOD_NS)
`define NCAO_CYC_ADL  ((`NCAO_T_ADL_NS + `NCAO_CLK_PERIOD_NS - 1) / `NCAO_CLK_PERIOD_NS)
`define NCAO_CYC_REA  ((`NCAO_T_REA_NS + `NCAO_CLK_PERIOD_NS - 1) / `NCAO_CLK_PERIOD_NS + 1)
`endif

// *** hdl/ncao_pkg.sv ***
// Types for the NAND column-address host controller.
// Assumes ncao_regs.svh is compiled alongside.
package ncao_pkg;
  typedef enum logic [1:0] {
    NCAO_OP_READ_COL,
    NCAO_OP_READ_PLANE,
    NCAO_OP_INPUT_COL,
    NCAO_OP_INPUT_ROW
  } ncao_op_t;
  typedef enum {
    NCAO_IDLE,
    NCAO_STAT_CMD,
    NCAO_STAT_ROW,
    NCAO_STAT_READ,
    NCAO_CMD,
    NCAO_COL,
    NCAO_ROW,
    NCAO_CONFIRM,
    NCAO_WAIT,
    NCAO_STREAM
  } ncao_state_t;
endpackage

// *** hdl/ncao_fifo.sv ***
// Small valid/ready FIFO for the data path of the NAND host.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module ncao_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doWrite;
  logic             doRead;

  // Handshakes on both sides
  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign doWrite  = inValid && inReady;
  assign doRead   = outValid && outReady;

  // Pointer and storage update
  always_ff @(posedge clock) begin
    if (!rstn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWrite) begin
        mem[wrPtr] <= inData;
        wrPtr      <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
    end
  end
endmodule

// *** verif/ncao_die_model.sv ***
// Behavioural NAND die driven through its command, address and data pins.
// Assumes the host launches strobes from its clock; the die has no clock.
`timescale 1ns/1ps
module ncao_die_model (
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic [7:0] ioOut,
  input  wire logic       ioOe,
  input  wire logic [7:0] statusByte,
  output logic      [7:0] ioIn
);
  logic [7:0]  cache [256];
  logic [7:0]  cmd;
  logic [15:0] col;
  logic [23:0] row;
  int          addrN;
  logic        outMode, statMode, inMode;

  // Known cache pattern so the host's reads can be predicted
  initial begin
    for (int i = 0; i < 256; i++) cache[i] = 8'(i) ^ 8'h5A;
    {outMode, statMode, inMode} = 3'b000;
    cmd = 8'h00;
    addrN = 0;
    col = 16'h0000;
    row = 24'h00_0000;
    ioIn = 8'h00;
  end

  // Latch command, address and data bytes on the rising write strobe
  always @(posedge we_n) begin
    if (cle) begin
      outMode = (ioOut == 8'hE0) && statusByte[6] && (cmd != 8'h06 || statusByte[5]);
      statMode = 0; // New command ends status output
      inMode = 0;
      cmd = ioOut;
      addrN = 0;
    end else if (ale) begin
      if (cmd == 8'h78) row[8*addrN +: 8] = ioOut;
      else if (addrN < 2) col[8*addrN +: 8] = ioOut; // Low byte first
      else row[8*(addrN-2) +: 8] = ioOut;
      statMode = (cmd == 8'h78) && (addrN == 2);
      inMode = (cmd == 8'h85) && (addrN >= 1);
      addrN++;
    end else if (inMode) begin
      cache[col[7:0]] = ioOut;
      col++;
    end
  end

  // Byte appears after the access time; inverted once the hold has run out
  always @(negedge re_n) begin
    ioIn <= #20 statMode ? statusByte : outMode ? cache[col[7:0]] : ~ioIn;
  end
  always @(posedge re_n) begin
    if (outMode && !statMode) col++;
    ioIn <= #60 ~ioIn;
  end
endmodule

// *** verif/ncao_host_asserts.sv ***
// Pin-timing and handshake checks for the NAND column-address host.
// Assumes it is bound to ncao_host and sees only that module's ports.
`timescale 1ns/1ps
module ncao_host_asserts (
  input wire logic               clock,
  input wire logic               rstn,
  input wire logic               opValid,
  input wire logic               opReady,
  input wire ncao_pkg::ncao_op_t opKind,
  input wire logic               opInProgram,
  input wire logic               opDone,
  input wire logic               opRefused,
  input wire logic               nandCle,
  input wire logic               nandAle,
  input wire logic               nandWe_n,
  input wire logic               nandRe_n,
  input wire logic [7:0]         nandIoOut,
  input wire logic               nandIoOe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // Host wait intervals after confirm and after the last address
  a_whr_wait: assert property (
    $rose(nandWe_n) && $past(nandCle) && $past(nandIoOut) == 8'hE0 |-> nandRe_n [*4])
    else $error("read strobe too soon after confirm");
  a_adl_wait: assert property (
    $rose(nandWe_n) && $past(nandAle) |-> !(!nandWe_n && !nandCle && !nandAle) [*4])
    else $error("data cycle too soon after address");
  // Bus cycle shape
  a_we_hold: assert property ($fell(nandWe_n) |-> !nandWe_n [*2])
    else $error("write strobe low phase too short");
  a_read_float: assert property (!nandRe_n |-> !nandIoOe && nandWe_n)
    else $error("host drives bus during read");
  a_write_drive: assert property (!nandWe_n |-> nandIoOe && !(nandCle && nandAle))
    else $error("bad write cycle qualifiers");
  // Completion pulses and refusal of misplaced input
  a_refuse_once: assert property (opRefused |=> !opRefused && !opDone)
    else $error("refusal pulse too long");
  a_done_once: assert property (opDone |=> !opDone)
    else $error("done pulse too long");
  a_input_gate: assert property (
    opValid && opReady && !opInProgram && opKind[1] |-> ##[1:2] opRefused)
    else $error("input outside program not refused");

  c_done: cover property (opDone);
  c_refused: cover property (opRefused);
  c_addr_end: cover property ($rose(nandWe_n) && $past(nandAle));
endmodule

bind ncao_host ncao_host_asserts u_chk (.clock, .rstn, .opValid, .opReady, .opKind,
  .opInProgram, .opDone, .opRefused, .nandCle, .nandAle, .nandWe_n, .nandRe_n,
  .nandIoOut, .nandIoOe);

// *** verif/tb.sv ***
// Self-checking bench: NAND column-address host against a behavioural die.
// Assumes package, FIFO, host, checker and die model are compiled first.
`timescale 1ns/1ps
module tb;
  typedef struct {ncao_pkg::ncao_op_t k; logic [15:0] c, n; logic m, p;
    logic [7:0] s; logic r, st;} ncao_case_t;
  logic               clock, rstn, opValid, opReady, opMultiDie, opInProgram, wrValid;
  logic               wrReady, rdValid, rdReady, opDone, opRefused, nandCle, nandAle;
  logic               nandWe_n, nandRe_n, nandIoOe;
  logic [15:0]        opColumn, opLength;
  logic [23:0]        opRow;
  logic [7:0]         wrData, rdData, nandIoOut, nandIoIn, dieStatus;
  logic [7:0]         exp [256];
  ncao_pkg::ncao_op_t opKind;
  int                 err_total, checked;
  // Kind, column, length, multi-die, program open, die status, refused, stall
  ncao_case_t cases [9] = '{
    '{ncao_pkg::NCAO_OP_READ_COL,   16'h0010, 16'h0003, 0, 0, 8'hC0, 0, 0},
    '{ncao_pkg::NCAO_OP_READ_PLANE, 16'h0020, 16'h0002, 0, 0, 8'hE0, 0, 0},
    '{ncao_pkg::NCAO_OP_READ_PLANE, 16'h0020, 16'h0002, 0, 0, 8'h40, 1, 0},
    '{ncao_pkg::NCAO_OP_READ_COL,   16'h0040, 16'h0002, 1, 0, 8'h40, 0, 0},
    '{ncao_pkg::NCAO_OP_READ_COL,   16'h0040, 16'h0002, 1, 0, 8'h00, 1, 0},
    '{ncao_pkg::NCAO_OP_INPUT_COL,  16'h0030, 16'h0003, 0, 0, 8'hC0, 1, 0},
    '{ncao_pkg::NCAO_OP_INPUT_COL,  16'h0030, 16'h0006, 0, 1, 8'hC0, 0, 1},
    '{ncao_pkg::NCAO_OP_INPUT_ROW,  16'h0080, 16'h0000, 1, 1, 8'hC0, 0, 0},
    '{ncao_pkg::NCAO_OP_READ_COL,   16'h0030, 16'h0006, 0, 0, 8'hC0, 0, 1}};

  ncao_host #(.DATA_DEPTH(4)) uut (.clock, .rstn, .opValid, .opReady, .opKind, .opColumn,
    .opRow, .opLength, .opMultiDie, .opInProgram, .wrData, .wrValid, .wrReady, .rdData,
    .rdValid, .rdReady, .opDone, .opRefused, .nandCle, .nandAle, .nandWe_n, .nandRe_n,
    .nandIoOut, .nandIoOe, .nandIoIn);
  ncao_die_model u_die (.cle(nandCle), .ale(nandAle), .we_n(nandWe_n), .re_n(nandRe_n),
    .ioOut(nandIoOut), .ioOe(nandIoOe), .statusByte(dieStatus), .ioIn(nandIoIn));

  // 40 MHz clock
  initial begin
    clock = 0;
    forever #12.5 clock = ~clock;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Hold reset, look at idle pins, then wait for the request port to open
  task automatic reset_check;
    int k;
    rstn <= 0;
    repeat (5) @(posedge clock);
    check(16'({nandCle, nandAle, nandWe_n, nandRe_n, nandIoOe, opReady, rdValid}), 16'h0018);
    rstn <= 1;
    for (k = 0; k < 4 && opReady !== 1; k++) @(posedge clock);
    check(16'(opReady), 16'h0001);
  endtask

  // Issue one operation, feed and drain the streams, check data and outcome
  task automatic run(input ncao_case_t cs);
    int k, wn, rn;
    logic fin, rf, full;
    wn = 0;
    rn = 0;
    fin = 0;
    rf = 0;
    full = 0;
    dieStatus <= cs.s;
    opKind <= cs.k;
    opColumn <= cs.c;
    opRow <= {8'h01, cs.c};
    opLength <= cs.n;
    opMultiDie <= cs.m;
    opInProgram <= cs.p;
    opValid <= 1;
    for (k = 0; k < 4000 && !(fin && (rf || cs.k[1] || rn >= cs.n)); k++) begin
      @(posedge clock);
      if (opValid && opReady === 1) opValid <= 0;
      if (wrValid && wrReady === 1) begin
        exp[cs.c + wn] = wrData;
        wn++;
      end
      if (wrValid && wrReady === 0) full = 1;
      if (rdValid === 1 && rdReady) begin
        check(16'(rdData), 16'(exp[cs.c + rn]));
        rn++;
      end
      if (opDone === 1 || opRefused === 1) begin
        fin = 1;
        rf = opRefused;
      end
      wrValid <= cs.k[1] && cs.p && wn < cs.n;
      wrData <= 8'hC0 + 8'(wn);
      rdReady <= !cs.st || k > 60;
    end
    if (k == 4000) begin
      err_total++;
      close_out;
    end else begin
      check(16'(rf), 16'(cs.r));
      if (cs.st && cs.k[1]) check(16'(full), 16'h0001);
    end
  endtask

  initial begin
    {opValid, opMultiDie, opInProgram, wrValid} = 4'h0;
    rdReady = 1;
    rstn = 0;
    opKind = ncao_pkg::NCAO_OP_READ_COL;
    opColumn = 16'h0000;
    opRow = 24'h00_0000;
    opLength = 16'h0000;
    wrData = 8'h00;
    dieStatus = 8'hC0;
    err_total = 0;
    checked = 0;
    for (int i = 0; i < 256; i++) exp[i] = 8'(i) ^ 8'h5A;
    @(posedge clock);
    reset_check();
    foreach (cases[i]) run(cases[i]);
    // Reset during the confirm cycle of a long read, before any data, then a clean read again
    opLength <= 16'h0008;
    opValid <= 1;
    repeat (2) @(posedge clock);
    opValid <= 0;
    repeat (20) @(posedge clock);
    reset_check();
    run(cases[0]);
    close_out;
  end
endmodule
